// file: rtl/pwm_deadband.sv
// pwm_deadband: delays the inactive-to-active edge of one output level.
// assumes level and count come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pwm_deadband (
	input wire logic clk,              // core clock
	input wire logic rstN,             // synchronised reset, active low
	input wire logic level,            // undelayed active level
	input wire logic [6:0] count,      // delay in instruction cycles
	output logic delayed               // delayed active level
);
	logic [6:0] cnt_q, cnt_d;
	logic out_q, out_d;

	// a falling level drops at once; a rising one waits count+1 cycles, so a
	// pulse shorter than the delay never shows at all
	always_comb begin
		cnt_d = cnt_q;
		out_d = out_q;
		if (!level) begin
			cnt_d = 7'h00;
			out_d = 1'b0;
		end else if (cnt_q >= count) begin
			out_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cnt_q <= 7'h00;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign delayed = out_q & level;

endmodule : pwm_deadband
`default_nettype wire

// file: rtl/pwm_out_pkg.sv
// pwm_out_pkg: register map, field layout and timing constants for the
// enhanced pwm output stage.
// assumes a 32-bit apb slave on a 100 MHz core clock.
package pwm_out_pkg;

	// register byte offsets
	localparam logic [7:0] UNIT_CTRL_OFS = 8'h00;
	localparam logic [7:0] SHUT_CTRL_OFS = 8'h04;
	localparam logic [7:0] DEADBAND_OFS = 8'h08;
	localparam logic [7:0] STEER_CTRL_OFS = 8'h0C;
	localparam logic [7:0] FLAG_OFS = 8'h10;

	// unit_control_reg fields
	localparam int OUT_MODE_LSB = 6;   // output_mode_field [7:6]
	localparam int UNIT_MODE_LSB = 0;  // unit_mode_field [3:0]
	localparam logic [1:0] PWM_ENABLE_CODE = 2'h3;
	localparam logic [1:0] OUT_SINGLE = 2'h0;
	localparam logic [1:0] OUT_HALF = 2'h2;

	// shutdown control fields
	localparam int SHUT_STAT_BIT = 7;  // shutdown_event_status
	localparam int SHUT_SRC_LSB = 4;   // shutdown_source_select [6:4]
	localparam int PAIR_ONE_LSB = 2;   // pair_one_shutdown_state [3:2]
	localparam int PAIR_TWO_LSB = 0;   // pair_two_shutdown_state [1:0]
	localparam int SRC_CMP1_BIT = 0;
	localparam int SRC_CMP2_BIT = 1;
	localparam int SRC_FAULT_BIT = 2;
	localparam logic [1:0] SHUT_DRIVE0 = 2'h0;
	localparam logic [1:0] SHUT_DRIVE1 = 2'h1;

	// deadband_control_reg fields
	localparam int RESTART_BIT = 7;    // auto_restart_enable

	// steering_control_reg fields
	localparam int STEER_SYNC_BIT = 4; // steer_sync_select

	// interrupt_flag_reg
	localparam int PERIOD_FLAG_BIT = 0; // timer_period_flag

	// timing
	localparam int DIR_WINDOW_COUNTS = 4;   // timer counts before period end
	localparam int CLK_PERIOD_NS = 10;
	localparam int INSTR_CYCLE_NS = 10;     // core clock is the instr. cycle
	localparam int INSTR_CLKS =
		(INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage : pwm_out_pkg

// file: rtl/pwm_output_ctrl.sv
// pwm_output_ctrl: enhanced pwm output stage with apb register access.
// assumes the timer, period match and duty compare live outside and feed
// tmrCount, tmrPeriod, periodStart and pwmIn on core_clk.
// Functional notes
// - full-bridge direction change takes effect from the next pwm cycle.
// - four counts before period end, B/D go inactive, A/C flip.
// - no dead-band delay in full-bridge; only half-bridge uses it.
// - direction bit may be written anytime; switch is still deferred.
// - three-bit source field picks fault-low or comparator-high triggers.
// - status bit set on shutdown, held until cleared or auto-restart.
// - shutdown forces enabled pairs asynchronously to drive 1, 0 or hi-z.
// - shutdown trigger is level based and holds while present.
// - status writes are ignored while a trigger is present.
// - after restart, output resumes only at the next period start.
// - writing 1 forces shutdown; auto-restart clears it immediately.
// - with auto-restart, status follows trigger and clears in hardware.
// - half-bridge delays inactive-to-active edges by a 7-bit count.
// - single mode steers the signal to any of outputs A to D.
// - low mode bits set polarity on steered outputs.
// - in steering, shutdown forces only steered outputs.
// - sync clear: new steering applies right after the write.
// - sync set: new steering waits for the next period start.
// - low mode bits set polarity for pair A/C and pair B/D.
// - period flag sets as the second pwm period begins.
// - forward holds A, modulates D; reverse holds C, modulates B.
// - dead-band longer than duty keeps that output inactive all cycle.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_ctrl (
	input wire logic core_clk,         // core clock, 100 MHz
	input wire logic nrst,             // async reset, active low
	input wire logic psel,             // apb select
	input wire logic penable,          // apb access phase
	input wire logic pwrite,           // apb write
	input wire logic [7:0] paddr,      // apb byte address
	input wire logic [31:0] pwdata,    // apb write data
	output logic [31:0] prdata,        // apb read data
	output logic pready,               // apb ready
	output logic pslverr,              // apb error, unmapped address
	input wire logic [7:0] tmrCount,   // timer count
	input wire logic [7:0] tmrPeriod,  // timer period match value
	input wire logic periodStart,      // pulse, first cycle of a period
	input wire logic pwmIn,            // modulated signal, active high
	input wire logic faultInN,         // fault_input pin, active low
	input wire logic [1:0] cmpOut,     // comparator outputs
	output logic [3:0] outData,        // output_a..output_d levels
	output logic [3:0] outEn           // pin output enables, high drives
);
	// reset release through two flops
	logic rstMeta_q, rstN;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta_q <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstN <= rstMeta_q;
		end
	end

	// trigger pins synchronised; first stage read only by the second
	logic [2:0] pinMeta_q, pinSync_q;
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			pinMeta_q <= 3'h1;
			pinSync_q <= 3'h1;
		end else begin
			pinMeta_q <= {cmpOut, faultInN};
			pinSync_q <= pinMeta_q;
		end
	end

	// source select decode, used for the synced and the raw path
	function automatic logic trigOf(input logic [2:0] src,
		input logic fltN, input logic [1:0] cmp);
		trigOf = (src[pwm_out_pkg::SRC_FAULT_BIT] & ~fltN)
			| (src[pwm_out_pkg::SRC_CMP1_BIT] & cmp[0])
			| (src[pwm_out_pkg::SRC_CMP2_BIT] & cmp[1]);
	endfunction : trigOf

	// software-visible registers
	logic [7:0] unitCtrl_q, unitCtrl_d;
	logic [6:0] shutCfg_q, shutCfg_d;     // source and pair states
	logic shutStat_q, shutStat_d;          // shutdown_event_status
	logic [7:0] deadCtrl_q, deadCtrl_d;
	logic [4:0] steerCtrl_q, steerCtrl_d;  // shadow enables and sync
	logic flag_q, flag_d;                  // timer_period_flag
	logic [31:0] rdata_q, rdata_d;

	logic setupWr, accessWr, setupRd, mapped;
	logic trigSync, trigRaw, autoRestart, wrShut;
	logic [1:0] outMode, polSel;
	logic pwmOn, fullBridge, halfBridge, singleMode;

	assign outMode = unitCtrl_q[pwm_out_pkg::OUT_MODE_LSB +: 2];
	assign polSel = unitCtrl_q[pwm_out_pkg::UNIT_MODE_LSB +: 2];
	assign pwmOn = unitCtrl_q[pwm_out_pkg::UNIT_MODE_LSB + 2 +: 2]
		== pwm_out_pkg::PWM_ENABLE_CODE;
	assign fullBridge = pwmOn && outMode[0];
	assign halfBridge = pwmOn && (outMode == pwm_out_pkg::OUT_HALF);
	assign singleMode = pwmOn && (outMode == pwm_out_pkg::OUT_SINGLE);
	assign autoRestart = deadCtrl_q[pwm_out_pkg::RESTART_BIT];
	assign trigSync = trigOf(shutCfg_q[pwm_out_pkg::SHUT_SRC_LSB +: 3],
		pinSync_q[0], pinSync_q[2:1]);
	// raw pin path: only gates the output mux, so a fault forces the pins
	// without waiting for a clock edge
	assign trigRaw = trigOf(shutCfg_q[pwm_out_pkg::SHUT_SRC_LSB +: 3],
		faultInN, cmpOut);

	// apb decode: zero wait states, read data captured in setup
	assign mapped = (paddr == pwm_out_pkg::UNIT_CTRL_OFS)
		|| (paddr == pwm_out_pkg::SHUT_CTRL_OFS)
		|| (paddr == pwm_out_pkg::DEADBAND_OFS)
		|| (paddr == pwm_out_pkg::STEER_CTRL_OFS)
		|| (paddr == pwm_out_pkg::FLAG_OFS);
	assign setupRd = psel && !penable && !pwrite;
	assign setupWr = psel && !penable && pwrite;
	assign accessWr = psel && penable && pwrite && mapped;
	assign wrShut = accessWr && (paddr == pwm_out_pkg::SHUT_CTRL_OFS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = rdata_q;

	// pwm sequencing state
	logic running_q, running_d;     // output allowed this period
	logic [1:0] periods_q, periods_d;
	logic hold_q, hold_d;           // waits for period start after restart
	logic dir_q, dir_d;             // applied direction, 1 = reverse
	logic swap_q, swap_d;           // inside the direction change window
	logic [3:0] steer_q, steer_d;   // applied steering enables
	logic inWindow, wantDir;

	// last four counts of the period, ending with the period match count
	assign inWindow = ({1'b0, tmrCount}
		+ 9'(pwm_out_pkg::DIR_WINDOW_COUNTS)) > {1'b0, tmrPeriod};
	assign wantDir = outMode[1];

	// register next values
	always_comb begin
		unitCtrl_d = unitCtrl_q;
		shutCfg_d = shutCfg_q;
		deadCtrl_d = deadCtrl_q;
		steerCtrl_d = steerCtrl_q;
		rdata_d = rdata_q;
		shutStat_d = shutStat_q;
		flag_d = flag_q;
		if (accessWr) begin
			case (paddr)
				pwm_out_pkg::UNIT_CTRL_OFS: unitCtrl_d = pwdata[7:0];
				pwm_out_pkg::SHUT_CTRL_OFS: shutCfg_d = pwdata[6:0];
				pwm_out_pkg::DEADBAND_OFS: deadCtrl_d = pwdata[7:0];
				pwm_out_pkg::STEER_CTRL_OFS: steerCtrl_d = pwdata[4:0];
				pwm_out_pkg::FLAG_OFS:
					flag_d = pwdata[pwm_out_pkg::PERIOD_FLAG_BIT];
				default: unitCtrl_d = unitCtrl_q;
			endcase
		end
		// status: writes blocked while a trigger is present
		if (wrShut && !trigSync) begin
			shutStat_d = pwdata[pwm_out_pkg::SHUT_STAT_BIT];
		end
		// auto-restart tracks only the pin and comparator sources; a
		// software shutdown stands one cycle so the hold path latches it
		if (autoRestart && !trigSync && !wrShut) begin
			shutStat_d = 1'b0;
		end
		if (trigSync) begin
			shutStat_d = 1'b1;
		end
		// hardware set wins over a software clear
		if (periodStart && periods_q == 2'h1) begin
			flag_d = 1'b1;
		end
		if (setupRd) begin
			case (paddr)
				pwm_out_pkg::UNIT_CTRL_OFS: rdata_d = {24'h0, unitCtrl_q};
				pwm_out_pkg::SHUT_CTRL_OFS:
					rdata_d = {24'h0, shutStat_q, shutCfg_q};
				pwm_out_pkg::DEADBAND_OFS: rdata_d = {24'h0, deadCtrl_q};
				pwm_out_pkg::STEER_CTRL_OFS:
					rdata_d = {27'h0, steerCtrl_q};
				pwm_out_pkg::FLAG_OFS: rdata_d = {31'h0, flag_q};
				default: rdata_d = pwm_out_pkg::RESET_WORD;
			endcase
		end else if (setupWr) begin
			rdata_d = pwm_out_pkg::RESET_WORD;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			unitCtrl_q <= 8'h00;
			shutCfg_q <= 7'h00;
			shutStat_q <= 1'b0;
			deadCtrl_q <= 8'h00;
			steerCtrl_q <= 5'h01;
			flag_q <= 1'b0;
			rdata_q <= pwm_out_pkg::RESET_WORD;
		end else begin
			unitCtrl_q <= unitCtrl_d;
			shutCfg_q <= shutCfg_d;
			shutStat_q <= shutStat_d;
			deadCtrl_q <= deadCtrl_d;
			steerCtrl_q <= steerCtrl_d;
			flag_q <= flag_d;
			rdata_q <= rdata_d;
		end
	end

	// sequencing next values
	always_comb begin
		running_d = running_q;
		periods_d = periods_q;
		hold_d = hold_q;
		dir_d = dir_q;
		swap_d = swap_q;
		steer_d = steer_q;
		if (!pwmOn) begin
			running_d = 1'b0;
			periods_d = 2'h0;
		end else if (periodStart) begin
			// first output only on a whole period
			running_d = 1'b1;
			if (periods_q != 2'h2) begin
				periods_d = periods_q + 2'h1;
			end
		end
		if (shutStat_q) begin
			hold_d = 1'b1;
		end else if (periodStart) begin
			hold_d = 1'b0;
		end
		if (!fullBridge) begin
			dir_d = wantDir;
			swap_d = 1'b0;
		end else if (periodStart) begin
			if (swap_q) begin
				dir_d = wantDir;
			end
			swap_d = 1'b0;
		end else if (inWindow && wantDir != dir_q) begin
			swap_d = 1'b1;
		end
		if (!steerCtrl_q[pwm_out_pkg::STEER_SYNC_BIT]) begin
			steer_d = steerCtrl_q[3:0];
		end else if (periodStart) begin
			steer_d = steerCtrl_q[3:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			running_q <= 1'b0;
			periods_q <= 2'h0;
			hold_q <= 1'b0;
			dir_q <= 1'b0;
			swap_q <= 1'b0;
			steer_q <= 4'h0;
		end else begin
			running_q <= running_d;
			periods_q <= periods_d;
			hold_q <= hold_d;
			dir_q <= dir_d;
			swap_q <= swap_d;
			steer_q <= steer_d;
		end
	end

	// half-bridge edges delayed; full-bridge bypasses the delay units
	logic halfA, halfB;
	pwm_deadband dbA (
		.clk(core_clk),
		.rstN(rstN),
		.level(pwmIn && halfBridge),
		.count(deadCtrl_q[6:0]),
		.delayed(halfA)
	);
	pwm_deadband dbB (
		.clk(core_clk),
		.rstN(rstN),
		.level(!pwmIn && halfBridge),
		.count(deadCtrl_q[6:0]),
		.delayed(halfB)
	);

	// active levels per mode, then polarity
	logic [3:0] act, pinUsed, drv_q, drv_d, polMask;
	logic pwmLive, aLvl;
	assign pwmLive = running_q && pwmIn;
	assign aLvl = swap_q ? !wantDir : !dir_q;
	assign polMask = {polSel[0], polSel[1], polSel[0], polSel[1]};

	always_comb begin
		act = 4'h0;
		pinUsed = 4'h0;
		if (singleMode) begin
			pinUsed = steer_q;
			act = {4{pwmLive}} & steer_q;
		end else if (halfBridge) begin
			pinUsed = 4'h3;
			act = {2'h0, running_q && halfB, running_q && halfA};
		end else if (fullBridge) begin
			pinUsed = 4'hF;
			// no delay unit on this path
			act[0] = running_q && aLvl;
			act[2] = running_q && !aLvl;
			act[1] = !swap_q && dir_q && pwmLive;
			act[3] = !swap_q && !dir_q && pwmLive;
		end
		drv_d = act ^ polMask;
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			drv_q <= 4'h0;
		end else begin
			drv_q <= drv_d;
		end
	end

	// shutdown mux on pin pairs A/C and B/D; hi-z drops the enable
	logic forced;
	logic [1:0] pairState [4];
	assign forced = shutStat_q || hold_q || trigRaw;
	assign pairState[0] = shutCfg_q[pwm_out_pkg::PAIR_ONE_LSB +: 2];
	assign pairState[2] = shutCfg_q[pwm_out_pkg::PAIR_ONE_LSB +: 2];
	assign pairState[1] = shutCfg_q[pwm_out_pkg::PAIR_TWO_LSB +: 2];
	assign pairState[3] = shutCfg_q[pwm_out_pkg::PAIR_TWO_LSB +: 2];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			// unsteered pins keep their state through a shutdown
			always_comb begin
				outData[gi] = drv_q[gi];
				outEn[gi] = pinUsed[gi];
				if (forced && pinUsed[gi]) begin
					outData[gi] = pairState[gi] == pwm_out_pkg::SHUT_DRIVE1;
					outEn[gi] = pairState[gi] == pwm_out_pkg::SHUT_DRIVE0
						|| pairState[gi] == pwm_out_pkg::SHUT_DRIVE1;
				end
			end
		end
	endgenerate

	// checks
	sequence s_trigSeen;
		trigSync;
	endsequence
	sequence s_statusUp;
		##1 shutStat_q;
	endsequence
	property p_shutSet;
		@(posedge core_clk) disable iff (!rstN)
		s_trigSeen |-> s_statusUp;
	endproperty
	a_shutSet: assert property (p_shutSet) else $error("status not set");
	property p_writeBlocked;
		@(posedge core_clk) disable iff (!rstN)
		(wrShut && trigSync) |=> shutStat_q;
	endproperty
	a_writeBlocked: assert property (p_writeBlocked)
		else $error("status cleared during trigger");
	property p_autoClear;
		@(posedge core_clk) disable iff (!rstN)
		(autoRestart && !trigSync && !wrShut) |=> !shutStat_q;
	endproperty
	a_autoClear: assert property (p_autoClear)
		else $error("auto-restart did not clear status");
	property p_forcedOut;
		@(posedge core_clk) disable iff (!rstN)
		(shutStat_q && singleMode && !steer_q[3]) |-> outData[3] == drv_q[3];
	endproperty
	a_forcedOut: assert property (p_forcedOut)
		else $error("unsteered pin forced");
	property p_holdPeriod;
		@(posedge core_clk) disable iff (!rstN)
		($fell(shutStat_q) && !periodStart) |-> hold_q;
	endproperty
	a_holdPeriod: assert property (p_holdPeriod)
		else $error("output resumed before period start");
	property p_dirDefer;
		@(posedge core_clk) disable iff (!rstN)
		(fullBridge && !periodStart) |=> $stable(dir_q) || !fullBridge;
	endproperty
	a_dirDefer: assert property (p_dirDefer)
		else $error("direction changed mid period");
	property p_swapQuiet;
		@(posedge core_clk) disable iff (!rstN)
		swap_q |-> ##1 (!drv_q[1] ^ polMask[1]) && (!drv_q[3] ^ polMask[3]);
	endproperty
	a_swapQuiet: assert property (p_swapQuiet)
		else $error("modulated output active in window");
	property p_syncSteer;
		@(posedge core_clk) disable iff (!rstN)
		(steerCtrl_q[pwm_out_pkg::STEER_SYNC_BIT] && !periodStart)
			|=> $stable(steer_q);
	endproperty
	a_syncSteer: assert property (p_syncSteer)
		else $error("synced steering changed mid period");
	property p_flagSecond;
		@(posedge core_clk) disable iff (!rstN)
		(pwmOn && periodStart && periods_q == 2'h1) |=> flag_q;
	endproperty
	a_flagSecond: assert property (p_flagSecond)
		else $error("period flag missing");

endmodule : pwm_output_ctrl
`default_nettype wire

// file: test/bridge_side_model.sv
// bridge_side_model: timer time base feeding the output stage, and the
// pull-downs on the bridge driver inputs.
// assumes one clock shared with the output stage.
`timescale 1ns/1ps
`default_nettype none
module bridge_side_model #(
	parameter int PERIOD = 19, // period match value
	parameter int DUTY = 8     // counts with the modulated level high
) (
	input wire logic clk,           // core clock
	input wire logic rstN,          // reset, active low
	input wire logic [3:0] outData, // levels from the output stage
	input wire logic [3:0] outEn,   // drive enables from the output stage
	output logic [7:0] tmrCount,    // timer count
	output logic [7:0] tmrPeriod,   // period match value
	output logic periodStart,       // first cycle of a period
	output logic pwmIn,             // modulated level
	output logic [3:0] pinLevel     // level seen by the switch drivers
);
	logic [7:0] count_q;
	// time base wraps to zero after the period match
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			count_q <= 8'h00;
		else if (count_q == 8'(PERIOD))
			count_q <= 8'h00;
		else
			count_q <= count_q + 8'h01;
	end
	// driven from the count so all are settled well before each edge
	assign tmrCount = count_q;
	assign tmrPeriod = 8'(PERIOD);
	assign periodStart = (count_q == 8'h00);
	assign pwmIn = (count_q < 8'(DUTY));
	// a released pin is pulled low so the switches stay off
	assign pinLevel = outData & outEn;
endmodule : bridge_side_model
`default_nettype wire

// file: test/test_pwm_output_ctrl.sv
// test_pwm_output_ctrl: self-checking bench for the pwm output stage.
// assumes the bridge model as time base with period 20 and duty 8.
`timescale 1ns/1ps
`default_nettype none
module test_pwm_output_ctrl;
	localparam logic [7:0] CTRL = pwm_out_pkg::UNIT_CTRL_OFS;
	localparam logic [7:0] SHUT = pwm_out_pkg::SHUT_CTRL_OFS;
	localparam logic [7:0] DBND = pwm_out_pkg::DEADBAND_OFS;
	localparam logic [7:0] STEER = pwm_out_pkg::STEER_CTRL_OFS;
	localparam logic [7:0] FLAG = pwm_out_pkg::FLAG_OFS;
	logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, periodStart, pwmIn, err;
	logic faultInN = 1'b1;
	logic [1:0] cmpOut = 2'h0;
	logic [7:0] paddr = 8'h00, tmrCount, tmrPeriod;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] outData, outEn, pinLevel;
	int num_errors = 0, comparisons = 0, cycles = 0, d0, d1;

	pwm_output_ctrl uut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tmrCount(tmrCount), .tmrPeriod(tmrPeriod),
		.periodStart(periodStart), .pwmIn(pwmIn), .faultInN(faultInN),
		.cmpOut(cmpOut), .outData(outData), .outEn(outEn));
	bridge_side_model model (.clk(core_clk), .rstN(nrst), .outData(outData),
		.outEn(outEn), .tmrCount(tmrCount), .tmrPeriod(tmrPeriod),
		.periodStart(periodStart), .pwmIn(pwmIn), .pinLevel(pinLevel));

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// a hang counts as a mismatch
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen high
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdchk

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	// returns once the stage has sampled the given count or period start
	task automatic at(input logic [7:0] c);
		do @(posedge core_clk); while (tmrCount !== c);
		#1;
	endtask : at

	task automatic start;
		at(8'h00);
	endtask : start

	// trigger pins change just after an edge, forcing is checked 1 ns on
	task automatic pin(input logic f, input logic [1:0] c);
		@(posedge core_clk);
		faultInN <= f;
		cmpOut <= c;
		#1;
	endtask : pin

	// cycles from a period start until output b goes high, 30 if never
	task automatic rise(input int b, output int d);
		start;
		d = 0;
		while (outData[b] !== 1'b1 && d < 30) begin
			@(posedge core_clk);
			#1;
			d++;
		end
	endtask : rise

	task automatic t_reset;
		chk(32'(outEn), 32'h0);
		rdchk(CTRL, 32'h0);
		rdchk(SHUT, 32'h0);
		rdchk(DBND, 32'h0);
		rdchk(STEER, 32'h1);
		rdchk(FLAG, 32'h0);
		bus(1'b0, 8'h14, 32'h0);
		chk(32'(err), 32'h1);
	endtask : t_reset

	// mode first, then one full cycle before pins are relied on
	task automatic t_startup;
		wr(CTRL, 32'h0C);
		start;
		tick(1);
		rdchk(FLAG, 32'h0);
		start;
		tick(1);
		rdchk(FLAG, 32'h1);
		wr(FLAG, 32'h0);
		rdchk(FLAG, 32'h0);
		chk(32'(outEn), 32'h1);
	endtask : t_startup

	task automatic t_steer;
		wr(STEER, 32'h0F);
		tick(1);
		chk(32'(outEn), 32'hF);
		wr(CTRL, 32'h0F);
		at(8'd3);
		chk(32'(outData), 32'h0);
		at(8'd12);
		chk(32'(outData), 32'hF);
		wr(STEER, 32'h13);
		tick(1);
		chk(32'(outEn), 32'hF);
		start;
		tick(1);
		chk(32'(outEn), 32'h3);
		wr(SHUT, 32'h44);
		pin(1'b0, 2'h0);
		chk(32'(outEn), 32'h3);
		chk(32'(outData[1:0]), 32'h1);
		pin(1'b1, 2'h0);
		tick(4);
		wr(SHUT, 32'h44);
		rdchk(SHUT, 32'h44);
	endtask : t_steer

	task automatic t_full;
		wr(CTRL, 32'h4C);
		start;
		at(8'd3);
		chk(32'(outEn), 32'hF);
		chk(32'(outData), 32'h9);
		wr(CTRL, 32'hCC);
		at(8'd12);
		chk(32'(outData), 32'h1);
		at(8'd18);
		chk(32'(outData), 32'h4);
		at(8'd3);
		chk(32'(outData), 32'h6);
	endtask : t_full

	task automatic t_shut;
		wr(SHUT, 32'h46);
		pin(1'b0, 2'h0);
		chk(32'(outEn), 32'h5);
		chk(32'(pinLevel), 32'h5);
		tick(4);
		rdchk(SHUT, 32'hC6);
		wr(SHUT, 32'h46);
		rdchk(SHUT, 32'hC6);
		pin(1'b1, 2'h0);
		tick(5);
		rdchk(SHUT, 32'hC6);
		at(8'd5);
		wr(SHUT, 32'h46);
		tick(1);
		chk(32'(outEn), 32'h5);
		start;
		tick(2);
		chk(32'(outEn), 32'hF);
		wr(DBND, 32'h80);
		wr(SHUT, 32'h11);
		pin(1'b1, 2'h2);
		tick(4);
		rdchk(SHUT, 32'h11);
		pin(1'b1, 2'h1);
		chk(32'(outData), 32'hA);
		tick(4);
		rdchk(SHUT, 32'h91);
		pin(1'b1, 2'h0);
		tick(6);
		rdchk(SHUT, 32'h11);
		wr(SHUT, 32'h21);
		pin(1'b1, 2'h2);
		tick(4);
		rdchk(SHUT, 32'hA1);
		pin(1'b1, 2'h0);
		tick(6);
		rdchk(SHUT, 32'h21);
		at(8'd5);
		wr(SHUT, 32'hA1);
		tick(3);
		chk(32'(outData), 32'hA);
		rdchk(SHUT, 32'h21);
		wr(DBND, 32'h0);
		wr(SHUT, 32'hA1);
		rdchk(SHUT, 32'hA1);
		chk(32'(outData), 32'hA);
		wr(SHUT, 32'h21);
	endtask : t_shut

	// delays compared against a zero-count run so latency cancels out
	task automatic t_dead;
		wr(CTRL, 32'h8C);
		rise(0, d0);
		rise(0, d0);
		wr(DBND, 32'h05);
		rise(0, d1);
		chk(32'(d1), 32'(d0 + 5));
		wr(DBND, 32'h64);
		rise(0, d1);
		chk(32'(d1), 32'd30);
		wr(CTRL, 32'h4C);
		wr(DBND, 32'h0);
		rise(3, d0);
		rise(3, d0);
		wr(DBND, 32'h05);
		rise(3, d1);
		chk(32'(d1), 32'(d0));
	endtask : t_dead

	// reset held three cycles, first request three edges after release
	initial begin
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset;
		t_startup;
		t_steer;
		t_full;
		t_shut;
		t_dead;
		tally_and_finish;
	end
endmodule : test_pwm_output_ctrl
`default_nettype wire
